// *** design/sbcsm_pkg.sv ***
/*
 * Shared types and constants for the bank command state machine:
 * command codes, bank and device states, pin bundle, timing figures.
 * Assumes a single 10 MHz clock.
 */
package sbcsm_pkg;

    localparam int CLK_PERIOD_NS = 100;
    // timing figures in ns, converted to cycles rounding up
    localparam int PRECHARGE_TIME_NS           = 20;
    localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
    localparam int REFRESH_CYCLE_TIME_NS       = 70;
    localparam int MODE_SET_DELAY_NS           = 200;
    localparam int SELF_REFRESH_EXIT_TIME_NS   = 80;
    localparam int BURST_LENGTH                = 4;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PRECHARGE_CYC = ns_to_cyc(PRECHARGE_TIME_NS);
    localparam int ACT_COL_CYC   = ns_to_cyc(ACTIVATE_TO_COLUMN_DELAY_NS);
    localparam int REFRESH_CYC   = ns_to_cyc(REFRESH_CYCLE_TIME_NS);
    localparam int MODE_SET_CYC  = ns_to_cyc(MODE_SET_DELAY_NS);
    localparam int SR_EXIT_CYC   = ns_to_cyc(SELF_REFRESH_EXIT_TIME_NS);

    localparam int NUM_BANKS   = 4;
    localparam int CNT_W       = 8;
    localparam int AP_BIT_POS  = 10;
    localparam int ADDR_W      = 12;

    typedef enum logic [3:0] {
        SBCSM_CMD_INHIBIT,
        SBCSM_CMD_NOP,
        SBCSM_CMD_ACTIVATE,
        SBCSM_CMD_READ,
        SBCSM_CMD_WRITE,
        SBCSM_CMD_PRECHARGE,
        SBCSM_CMD_BURST_STOP,
        SBCSM_CMD_REFRESH,
        SBCSM_CMD_LOAD_MODE
    } sbcsm_cmd_t;

    typedef enum logic [2:0] {
        SBCSM_BANK_IDLE,
        SBCSM_BANK_ACTIVATING,
        SBCSM_BANK_ACTIVE,
        SBCSM_BANK_READ,
        SBCSM_BANK_WRITE,
        SBCSM_BANK_READ_AP,
        SBCSM_BANK_WRITE_AP,
        SBCSM_BANK_PRECHARGING
    } sbcsm_bank_st_t;

    typedef enum logic [2:0] {
        SBCSM_DEV_NORMAL,
        SBCSM_DEV_REFRESHING,
        SBCSM_DEV_MODE_ACCESS,
        SBCSM_DEV_PRECHARGE_ALL,
        SBCSM_DEV_SR_EXIT
    } sbcsm_dev_st_t;

    // command pins as sampled
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [1:0]        bank_addr;
        logic [ADDR_W-1:0] addr;
    } sbcsm_pins_t;

    // one decoded, qualified command
    typedef struct packed {
        sbcsm_cmd_t cmd;
        logic [1:0] bank;
        logic       ap;
        logic       valid;
    } sbcsm_dec_t;

endpackage

// *** design/sbcsm_decode.sv ***
/*
 * Command decoder: turns the chip select and strobe pins into a
 * command code, bank and auto-precharge flag.
 * Assumes pins are already synchronised to i_mclk.
 */
`timescale 1ns/1ns
module sbcsm_decode
    import sbcsm_pkg::*;
(
    input  wire sbcsm_pkg::sbcsm_pins_t i_pins,
    input  wire logic                   i_rules_on,
    output sbcsm_pkg::sbcsm_dec_t       o_dec
);

    always_comb begin
        o_dec.bank  = i_pins.bank_addr;
        o_dec.ap    = i_pins.addr[AP_BIT_POS];
        o_dec.valid = i_rules_on;
        if (i_pins.cs_n) begin
            o_dec.cmd = SBCSM_CMD_INHIBIT;
        end else begin
            unique case ({i_pins.ras_n, i_pins.cas_n, i_pins.we_n})
                3'b111: o_dec.cmd = SBCSM_CMD_NOP;
                3'b011: o_dec.cmd = SBCSM_CMD_ACTIVATE;
                3'b101: o_dec.cmd = SBCSM_CMD_READ;
                3'b100: o_dec.cmd = SBCSM_CMD_WRITE;
                3'b010: o_dec.cmd = SBCSM_CMD_PRECHARGE;
                3'b110: o_dec.cmd = SBCSM_CMD_BURST_STOP;
                3'b001: o_dec.cmd = SBCSM_CMD_REFRESH;
                3'b000: o_dec.cmd = SBCSM_CMD_LOAD_MODE;
            endcase
        end
    end

endmodule // sbcsm_decode

// *** design/sbcsm_bank.sv ***
/*
 * One bank's state record with its own timer.
 * Assumes the caller has already judged legality and passes only
 * accepted commands for this bank.
 */
`timescale 1ns/1ns
module sbcsm_bank
    import sbcsm_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic                   i_act,
    input  wire logic                   i_rd,
    input  wire logic                   i_wr,
    input  wire logic                   i_ap,
    input  wire logic                   i_pre,
    input  wire logic                   i_burst_end,
    input  wire logic                   i_force_idle,
    output sbcsm_pkg::sbcsm_bank_st_t   o_state
);

    typedef struct packed {
        sbcsm_bank_st_t   st;
        logic [CNT_W-1:0] cnt;
    } sbcsm_bank_reg_t;

    sbcsm_bank_reg_t r_q;
    sbcsm_bank_reg_t r_d;

    always_comb begin
        r_d = r_q;
        if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 1'b1;
        end
        if (i_force_idle) begin
            r_d.st  = SBCSM_BANK_IDLE;
            r_d.cnt = '0;
        end else if (i_act) begin
            r_d.st  = SBCSM_BANK_ACTIVATING;
            r_d.cnt = CNT_W'(ACT_COL_CYC - 1);
        end else if (i_pre && r_q.st != SBCSM_BANK_IDLE) begin
            r_d.st  = SBCSM_BANK_PRECHARGING;
            r_d.cnt = CNT_W'(PRECHARGE_CYC - 1);
        end else if (i_rd || i_wr) begin
            if (i_ap) begin
                r_d.st  = i_rd ? SBCSM_BANK_READ_AP : SBCSM_BANK_WRITE_AP;
                r_d.cnt = CNT_W'(BURST_LENGTH + PRECHARGE_CYC - 1);
            end else begin
                r_d.st  = i_rd ? SBCSM_BANK_READ : SBCSM_BANK_WRITE;
                r_d.cnt = CNT_W'(BURST_LENGTH - 1);
            end
        end else if (i_burst_end &&
                     (r_q.st == SBCSM_BANK_READ ||
                      r_q.st == SBCSM_BANK_WRITE)) begin
            r_d.st  = SBCSM_BANK_ACTIVE;
            r_d.cnt = '0;
        end else if (r_q.cnt == '0) begin
            unique case (r_q.st)
                SBCSM_BANK_ACTIVATING:  r_d.st = SBCSM_BANK_ACTIVE;
                SBCSM_BANK_READ,
                SBCSM_BANK_WRITE:       r_d.st = SBCSM_BANK_ACTIVE;
                SBCSM_BANK_READ_AP,
                SBCSM_BANK_WRITE_AP:    r_d.st = SBCSM_BANK_IDLE;
                SBCSM_BANK_PRECHARGING: r_d.st = SBCSM_BANK_IDLE;
                SBCSM_BANK_IDLE,
                SBCSM_BANK_ACTIVE:      r_d.st = r_q.st;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_q <= '{st: SBCSM_BANK_IDLE, cnt: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_state = r_q.st;

endmodule // sbcsm_bank

// *** design/sbcsm_top.sv ***
/*
 * Bank command state machine of a quad-bank synchronous DRAM.
 * Samples the command pins, decodes them, judges each command
 * against the bank and device states, and tracks all four banks.
 * Assumes pins arrive from outside the clock domain; the controller
 * keeps the rules that bind it.
 */
`timescale 1ns/1ns
module sbcsm_top
    import sbcsm_pkg::*;
#(
    parameter int NUM_BANKS_P = sbcsm_pkg::NUM_BANKS
) (
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    input  wire logic                      i_cke,
    input  wire sbcsm_pkg::sbcsm_pins_t    i_pins,
    output sbcsm_pkg::sbcsm_bank_st_t      o_bank_state [NUM_BANKS_P],
    output sbcsm_pkg::sbcsm_dev_st_t       o_dev_state,
    output sbcsm_pkg::sbcsm_cmd_t          o_cmd,
    output logic                           o_cmd_accepted,
    output logic                           o_cmd_illegal,
    output logic                           o_all_idle
);

    ////////////////////////////////////////////////////////////////////
    // state record

    typedef struct packed {
        sbcsm_pins_t      pins_m;
        sbcsm_pins_t      pins_s;
        logic             cke_m;
        logic             cke_s;
        logic             cke_prev;
        sbcsm_dev_st_t    dev;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       last_bank;
        logic             last_valid;
        sbcsm_cmd_t       cmd;
        logic             accepted;
        logic             illegal;
    } sbcsm_top_reg_t;

    sbcsm_top_reg_t r_q;
    sbcsm_top_reg_t r_d;

    sbcsm_dec_t     dec;
    sbcsm_bank_st_t bst [NUM_BANKS_P];

    logic [NUM_BANKS_P-1:0] b_act;
    logic [NUM_BANKS_P-1:0] b_rd;
    logic [NUM_BANKS_P-1:0] b_wr;
    logic [NUM_BANKS_P-1:0] b_pre;
    logic [NUM_BANKS_P-1:0] b_stop;
    logic                   force_idle;
    logic                   rules_on;
    logic                   all_idle;
    logic                   legal;
    logic                   pre_all_ok;
    sbcsm_bank_st_t         tgt;

    ////////////////////////////////////////////////////////////////////
    // decode

    // rules need clock enable high at this and the previous edge
    assign rules_on = r_q.cke_s && r_q.cke_prev &&
                      (r_q.dev != SBCSM_DEV_SR_EXIT);

    sbcsm_decode u_decode (
        .i_pins     (r_q.pins_s),
        .i_rules_on (rules_on),
        .o_dec      (dec)
    );

    always_comb begin
        all_idle   = 1'b1;
        pre_all_ok = 1'b1;
        for (int i = 0; i < NUM_BANKS_P; i++) begin
            if (bst[i] != SBCSM_BANK_IDLE) begin
                all_idle = 1'b0;
            end
            if (bst[i] == SBCSM_BANK_ACTIVATING ||
                bst[i] == SBCSM_BANK_READ_AP ||
                bst[i] == SBCSM_BANK_WRITE_AP) begin
                pre_all_ok = 1'b0;
            end
        end
    end

    assign tgt = bst[dec.bank];

    ////////////////////////////////////////////////////////////////////
    // legality of the command against bank and device state

    always_comb begin
        legal = 1'b1;
        if (!dec.valid || r_q.dev != SBCSM_DEV_NORMAL) begin
            // device-wide states admit only inhibit or no-op
            legal = (dec.cmd == SBCSM_CMD_INHIBIT ||
                     dec.cmd == SBCSM_CMD_NOP);
        end else begin
            unique case (dec.cmd)
                SBCSM_CMD_INHIBIT,
                SBCSM_CMD_NOP:        legal = 1'b1;
                SBCSM_CMD_ACTIVATE:   legal = (tgt == SBCSM_BANK_IDLE);
                SBCSM_CMD_READ,
                SBCSM_CMD_WRITE:      legal = (tgt == SBCSM_BANK_ACTIVE ||
                                               tgt == SBCSM_BANK_READ ||
                                               tgt == SBCSM_BANK_WRITE);
                SBCSM_CMD_PRECHARGE:  legal = dec.ap ? pre_all_ok :
                                        (tgt == SBCSM_BANK_IDLE ||
                                         tgt == SBCSM_BANK_ACTIVE ||
                                         tgt == SBCSM_BANK_READ ||
                                         tgt == SBCSM_BANK_WRITE);
                SBCSM_CMD_BURST_STOP: legal = r_q.last_valid;
                SBCSM_CMD_REFRESH,
                SBCSM_CMD_LOAD_MODE:  legal = all_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-bank strobes

    always_comb begin
        b_act  = '0;
        b_rd   = '0;
        b_wr   = '0;
        b_pre  = '0;
        b_stop = '0;
        if (legal && dec.valid && r_q.dev == SBCSM_DEV_NORMAL) begin
            unique case (dec.cmd)
                SBCSM_CMD_ACTIVATE:   b_act[dec.bank] = 1'b1;
                SBCSM_CMD_READ:       b_rd[dec.bank]  = 1'b1;
                SBCSM_CMD_WRITE:      b_wr[dec.bank]  = 1'b1;
                SBCSM_CMD_PRECHARGE:  b_pre = dec.ap ? '1 :
                    (NUM_BANKS_P'(1) << dec.bank);
                SBCSM_CMD_BURST_STOP: b_stop[r_q.last_bank] = 1'b1;
                default: ;
            endcase
            // a new access elsewhere ends a running burst without auto-precharge
            if (dec.cmd == SBCSM_CMD_READ || dec.cmd == SBCSM_CMD_WRITE) begin
                for (int i = 0; i < NUM_BANKS_P; i++) begin
                    if (i != int'(dec.bank)) begin
                        b_stop[i] = 1'b1;
                    end
                end
            end
        end
    end

    assign force_idle = (r_q.dev != SBCSM_DEV_NORMAL &&
                         r_q.dev != SBCSM_DEV_SR_EXIT &&
                         r_q.cnt == '0);

    ////////////////////////////////////////////////////////////////////
    // bank records

    for (genvar g = 0; g < NUM_BANKS_P; g++) begin : g_bank
        sbcsm_bank u_bank (
            .i_mclk       (i_mclk),
            .i_rst        (i_rst),
            .i_act        (b_act[g]),
            .i_rd         (b_rd[g]),
            .i_wr         (b_wr[g]),
            .i_ap         (dec.ap),
            .i_pre        (b_pre[g] && !(dec.ap && dec.cmd ==
                                         SBCSM_CMD_PRECHARGE)),
            .i_burst_end  (b_stop[g]),
            .i_force_idle (force_idle),
            .o_state      (bst[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // device-wide state and pin sampling

    always_comb begin
        r_d          = r_q;
        r_d.pins_m   = i_pins;
        r_d.pins_s   = r_q.pins_m;
        r_d.cke_m    = i_cke;
        r_d.cke_s    = r_q.cke_m;
        r_d.cke_prev = r_q.cke_s;
        r_d.cmd      = dec.cmd;
        r_d.accepted = legal && dec.cmd != SBCSM_CMD_INHIBIT &&
                       dec.cmd != SBCSM_CMD_NOP;
        r_d.illegal  = !legal;
        if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 1'b1;
        end
        unique case (r_q.dev)
            SBCSM_DEV_NORMAL: begin
                if (!r_q.cke_prev && r_q.cke_s) begin
                    r_d.dev = SBCSM_DEV_SR_EXIT;
                    r_d.cnt = CNT_W'(SR_EXIT_CYC - 1);
                end else if (legal && dec.valid) begin
                    unique case (dec.cmd)
                        SBCSM_CMD_REFRESH: begin
                            r_d.dev = SBCSM_DEV_REFRESHING;
                            r_d.cnt = CNT_W'(REFRESH_CYC - 1);
                        end
                        SBCSM_CMD_LOAD_MODE: begin
                            r_d.dev = SBCSM_DEV_MODE_ACCESS;
                            r_d.cnt = CNT_W'(MODE_SET_CYC - 1);
                        end
                        SBCSM_CMD_PRECHARGE: begin
                            if (dec.ap) begin
                                r_d.dev = SBCSM_DEV_PRECHARGE_ALL;
                                r_d.cnt = CNT_W'(PRECHARGE_CYC - 1);
                            end
                        end
                        SBCSM_CMD_READ,
                        SBCSM_CMD_WRITE: begin
                            r_d.last_bank  = dec.bank;
                            r_d.last_valid = 1'b1;
                        end
                        SBCSM_CMD_BURST_STOP: r_d.last_valid = 1'b0;
                        default: ;
                    endcase
                end
            end
            SBCSM_DEV_REFRESHING,
            SBCSM_DEV_MODE_ACCESS,
            SBCSM_DEV_PRECHARGE_ALL: begin
                if (r_q.cnt == '0) begin
                    r_d.dev        = SBCSM_DEV_NORMAL;
                    r_d.last_valid = 1'b0;
                end
            end
            SBCSM_DEV_SR_EXIT: begin
                if (r_q.cnt == '0) begin
                    r_d.dev = SBCSM_DEV_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_q <= '{pins_m: '1, pins_s: '1, cke_m: 1'b0, cke_s: 1'b0,
                     cke_prev: 1'b0, dev: SBCSM_DEV_NORMAL, cnt: '0,
                     last_bank: 2'h0, last_valid: 1'b0,
                     cmd: SBCSM_CMD_INHIBIT, accepted: 1'b0,
                     illegal: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_bank_state   = bst;
    assign o_dev_state    = r_q.dev;
    assign o_cmd          = r_q.cmd;
    assign o_cmd_accepted = r_q.accepted;
    assign o_cmd_illegal  = r_q.illegal;
    assign o_all_idle     = all_idle && r_q.dev == SBCSM_DEV_NORMAL;

endmodule // sbcsm_top

// *** testbench/sbcsm_ctl_model.sv ***
/* Controller model: turns a command request into command pins,
   launched on the rising edge after the request.
   Assumes the bench never asks for a command the rules forbid
   unless it expects a refusal. */
`timescale 1ns/1ns
module sbcsm_ctl_model
    import sbcsm_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire sbcsm_pkg::sbcsm_cmd_t i_cmd,
    input  wire logic [1:0]            i_bank,
    input  wire logic                  i_ap,
    input  wire logic [11:0]           i_row,
    output sbcsm_pkg::sbcsm_pins_t     o_pins
);
    import sbcsm_pkg::*;

    function automatic logic [2:0] enc(sbcsm_cmd_t c, logic [2:0] r);
        case (c)
            SBCSM_CMD_ACTIVATE:   return 3'h3;
            SBCSM_CMD_READ:       return 3'h5;
            SBCSM_CMD_WRITE:      return 3'h4;
            SBCSM_CMD_PRECHARGE:  return 3'h2;
            SBCSM_CMD_BURST_STOP: return 3'h6;
            SBCSM_CMD_REFRESH:    return 3'h1;
            SBCSM_CMD_LOAD_MODE:  return 3'h0;
            SBCSM_CMD_INHIBIT:    return r;
            default:              return 3'h7;
        endcase
    endfunction

    initial o_pins = '1;

    always @(posedge i_mclk) begin
        o_pins.cs_n      <= (i_cmd == SBCSM_CMD_INHIBIT);
        o_pins.bank_addr <= i_bank;
        o_pins.addr      <= {i_row[11], i_ap, i_row[9:0]};
        {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= enc(i_cmd, i_row[2:0]);
    end
endmodule // sbcsm_ctl_model

// *** testbench/sbcsm_checker.sv ***
/* Checker: command decode and bank/device state moves of sbcsm_top.
   Sees the top's ports only; bound below. */
`timescale 1ns/1ns
module sbcsm_checker
    import sbcsm_pkg::*;
#(
    parameter int NUM_BANKS_P = sbcsm_pkg::NUM_BANKS
) (
    input wire logic                      i_mclk,
    input wire logic                      i_rst,
    input wire logic                      i_cke,
    input wire sbcsm_pkg::sbcsm_pins_t    i_pins,
    input wire sbcsm_pkg::sbcsm_bank_st_t o_bank_state [NUM_BANKS_P],
    input wire sbcsm_pkg::sbcsm_dev_st_t  o_dev_state,
    input wire sbcsm_pkg::sbcsm_cmd_t     o_cmd,
    input wire logic                      o_cmd_accepted,
    input wire logic                      o_cmd_illegal,
    input wire logic                      o_all_idle
);
    import sbcsm_pkg::*;
    sbcsm_pins_t    p1_q;
    sbcsm_pins_t    p2_q;
    sbcsm_pins_t    p3_q;
    sbcsm_bank_st_t st_q [NUM_BANKS_P];
    logic [3:0]     cke_q;
    logic [1:0]     b;
    logic           ok;
    logic           act;
    logic           pre1;

    function automatic sbcsm_cmd_t dec(sbcsm_pins_t p);
        if (p.cs_n)
            return SBCSM_CMD_INHIBIT;
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h3: return SBCSM_CMD_ACTIVATE;
            3'h5: return SBCSM_CMD_READ;
            3'h4: return SBCSM_CMD_WRITE;
            3'h2: return SBCSM_CMD_PRECHARGE;
            3'h6: return SBCSM_CMD_BURST_STOP;
            3'h1: return SBCSM_CMD_REFRESH;
            3'h0: return SBCSM_CMD_LOAD_MODE;
            default: return SBCSM_CMD_NOP;
        endcase
    endfunction

    // pins delayed to line up with the registered answer
    assign b    = p3_q.bank_addr;
    assign ok   = o_cmd_accepted;
    assign act  = ok && o_cmd == SBCSM_CMD_ACTIVATE;
    assign pre1 = ok && o_cmd == SBCSM_CMD_PRECHARGE
                  && !p3_q.addr[AP_BIT_POS];

    always_ff @(posedge i_mclk) begin
        p1_q <= i_pins;
        p2_q <= p1_q;
        p3_q <= p2_q;
        st_q <= o_bank_state;
        if (i_rst || !i_cke)
            cke_q <= 4'h0;
        else if (cke_q != 4'hF)
            cke_q <= cke_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    AST_DECODE: assert property (
        cke_q == 4'hF |-> o_cmd == dec(p3_q)) else $error("bad decode");
    AST_QUIET: assert property (
        o_cmd inside {SBCSM_CMD_INHIBIT, SBCSM_CMD_NOP}
        |-> !ok && !o_cmd_illegal) else $error("no-op flagged");
    AST_ACT: assert property (
        act |-> o_bank_state[b] == SBCSM_BANK_ACTIVATING
        ##1 o_bank_state[$past(b)] == SBCSM_BANK_ACTIVE)
        else $error("activate timing");
    AST_PRE: assert property (
        pre1 && st_q[b] != SBCSM_BANK_IDLE
        |-> o_bank_state[b] == SBCSM_BANK_PRECHARGING
        ##1 o_bank_state[$past(b)] == SBCSM_BANK_IDLE)
        else $error("precharge timing");
    AST_PRE_IDLE: assert property (
        pre1 && st_q[b] == SBCSM_BANK_IDLE
        |-> o_bank_state[b] == SBCSM_BANK_IDLE) else $error("idle moved");
    AST_PREALL: assert property (
        ok && o_cmd == SBCSM_CMD_PRECHARGE && p3_q.addr[AP_BIT_POS]
        |-> o_dev_state == SBCSM_DEV_PRECHARGE_ALL ##1 o_all_idle)
        else $error("precharge all");
    AST_REF: assert property (
        ok && o_cmd == SBCSM_CMD_REFRESH |-> $past(o_all_idle)
        && o_dev_state == SBCSM_DEV_REFRESHING ##1 o_all_idle)
        else $error("refresh");
    AST_MODE: assert property (
        ok && o_cmd == SBCSM_CMD_LOAD_MODE
        |-> o_dev_state == SBCSM_DEV_MODE_ACCESS [*2] ##1 o_all_idle)
        else $error("mode access");
    AST_BUSY: assert property (
        ok |-> !o_cmd_illegal && $past(o_dev_state) == SBCSM_DEV_NORMAL)
        else $error("accepted while busy");

    cover property (act);
    cover property (pre1);
    cover property (ok && o_cmd == SBCSM_CMD_LOAD_MODE);
endmodule // sbcsm_checker

bind sbcsm_top sbcsm_checker #(.NUM_BANKS_P(NUM_BANKS_P)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_cke(i_cke), .i_pins(i_pins),
    .o_bank_state(o_bank_state), .o_dev_state(o_dev_state),
    .o_cmd(o_cmd), .o_cmd_accepted(o_cmd_accepted),
    .o_cmd_illegal(o_cmd_illegal), .o_all_idle(o_all_idle));

// *** testbench/sbcsm_tb.sv ***
/* Bench for sbcsm_top: commands go through the controller model;
   flags and states are compared. Assumes the checker is bound. */
`timescale 1ns/1ns
module sbcsm_tb;
    import sbcsm_pkg::*;
    logic           i_mclk;
    logic           i_rst;
    logic           i_cke;
    sbcsm_cmd_t     c_cmd;
    logic [1:0]     c_bank;
    logic           c_ap;
    logic [11:0]    c_row;
    sbcsm_pins_t    pins;
    sbcsm_bank_st_t bst [NUM_BANKS];
    sbcsm_dev_st_t  dst;
    sbcsm_cmd_t     ocmd;
    logic           acc;
    logic           ill;
    logic           aidle;
    int             fail_count;
    int             checks_done;
    int             seed;
    int             cyc;

    sbcsm_ctl_model CTL (.i_mclk(i_mclk), .i_cmd(c_cmd), .i_bank(c_bank),
        .i_ap(c_ap), .i_row(c_row), .o_pins(pins));
    sbcsm_top #(.NUM_BANKS_P(NUM_BANKS)) DUT (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_cke(i_cke), .i_pins(pins), .o_bank_state(bst),
        .o_dev_state(dst), .o_cmd(ocmd), .o_cmd_accepted(acc),
        .o_cmd_illegal(ill), .o_all_idle(aidle));

    task automatic final_report;
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_bit(string n, logic e, logic s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s exp %b got %b", n, e, s);
        end
    endtask

    task automatic chk_st(int b, sbcsm_bank_st_t e);
        checks_done++;
        if (bst[b] !== e) begin
            fail_count++;
            $display("mismatch bank%0d exp %s got %s", b, e.name(),
                     bst[b].name());
        end
    endtask

    task automatic chk_dev(sbcsm_dev_st_t e);
        checks_done++;
        if (dst !== e) begin
            fail_count++;
            $display("mismatch dev exp %s got %s", e.name(), dst.name());
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic send(sbcsm_cmd_t c, int b, int ap);
        @(posedge i_mclk);
        c_cmd  <= c;
        c_bank <= 2'(b);
        c_ap   <= 1'(ap);
        c_row  <= 12'($random(seed));
        @(posedge i_mclk);
        c_cmd  <= SBCSM_CMD_NOP;
    endtask

    // bounded wait for the one-cycle answer flag
    task automatic resp(int ok);
        int n;
        n = 0;
        @(negedge i_mclk);
        while (acc !== 1'b1 && ill !== 1'b1 && n < 8) begin
            @(negedge i_mclk);
            n++;
        end
        chk_bit("accepted", 1'(ok), acc);
        chk_bit("illegal", 1'(!ok), ill);
    endtask

    task automatic go(sbcsm_cmd_t c, int b, int ap, int ok);
        send(c, b, ap);
        resp(ok);
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    initial begin
        cyc = 0;
        forever begin
            @(posedge i_mclk);
            cyc++;
            if (cyc == 2000) begin
                fail_count++;
                final_report();
            end
        end
    end

    initial begin
        seed = 84;
        fail_count = 0;
        checks_done = 0;
        i_rst = 1'b1;
        i_cke = 1'b1;
        c_cmd = SBCSM_CMD_INHIBIT;
        c_bank = 2'h0;
        c_ap = 1'b0;
        c_row = 12'h000;
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (8) @(negedge i_mclk);
        chk_bit("all_idle", 1'b1, aidle);
        for (int k = 0; k < 4; k++) chk_st(k, SBCSM_BANK_IDLE);
        go(SBCSM_CMD_ACTIVATE, 0, 0, 1);
        chk_st(0, SBCSM_BANK_ACTIVATING);
        @(negedge i_mclk);
        chk_st(0, SBCSM_BANK_ACTIVE);
        go(SBCSM_CMD_ACTIVATE, 0, 0, 0);
        go(SBCSM_CMD_REFRESH, 0, 0, 0);
        go(SBCSM_CMD_READ, 3, 0, 0);
        send(SBCSM_CMD_READ, 0, 0);
        send(SBCSM_CMD_WRITE, 0, 0);
        resp(1);
        chk_st(0, SBCSM_BANK_READ);
        send(SBCSM_CMD_BURST_STOP, 2, 0);
        resp(1);
        chk_st(0, SBCSM_BANK_WRITE);
        resp(1);
        chk_st(0, SBCSM_BANK_ACTIVE);
        go(SBCSM_CMD_BURST_STOP, 0, 0, 0);
        go(SBCSM_CMD_ACTIVATE, 1, 0, 1);
        @(negedge i_mclk);
        send(SBCSM_CMD_WRITE, 0, 0);
        send(SBCSM_CMD_READ, 1, 0);
        resp(1);
        resp(1);
        chk_st(0, SBCSM_BANK_ACTIVE);
        chk_st(1, SBCSM_BANK_READ);
        go(SBCSM_CMD_READ, 1, 1, 1);
        chk_st(1, SBCSM_BANK_READ_AP);
        repeat (6) @(negedge i_mclk);
        chk_st(1, SBCSM_BANK_IDLE);
        go(SBCSM_CMD_PRECHARGE, 1, 0, 1);
        chk_st(1, SBCSM_BANK_IDLE);
        go(SBCSM_CMD_WRITE, 0, 1, 1);
        chk_st(0, SBCSM_BANK_WRITE_AP);
        repeat (6) @(negedge i_mclk);
        chk_st(0, SBCSM_BANK_IDLE);
        send(SBCSM_CMD_ACTIVATE, 0, 0);
        send(SBCSM_CMD_ACTIVATE, 2, 0);
        resp(1);
        resp(1);
        @(negedge i_mclk);
        go(SBCSM_CMD_PRECHARGE, 2, 0, 1);
        chk_st(2, SBCSM_BANK_PRECHARGING);
        @(negedge i_mclk);
        chk_st(2, SBCSM_BANK_IDLE);
        go(SBCSM_CMD_PRECHARGE, 3, 1, 1);
        chk_dev(SBCSM_DEV_PRECHARGE_ALL);
        repeat (2) @(negedge i_mclk);
        chk_bit("all_idle", 1'b1, aidle);
        go(SBCSM_CMD_REFRESH, 0, 0, 1);
        chk_dev(SBCSM_DEV_REFRESHING);
        @(negedge i_mclk);
        chk_bit("all_idle", 1'b1, aidle);
        go(SBCSM_CMD_LOAD_MODE, 0, 0, 1);
        chk_dev(SBCSM_DEV_MODE_ACCESS);
        repeat (2) @(negedge i_mclk);
        chk_bit("all_idle", 1'b1, aidle);
        @(posedge i_mclk);
        i_cke <= 1'b0;
        go(SBCSM_CMD_ACTIVATE, 3, 0, 0);
        chk_st(3, SBCSM_BANK_IDLE);
        @(posedge i_mclk);
        i_cke <= 1'b1;
        repeat (10) @(negedge i_mclk);
        go(SBCSM_CMD_ACTIVATE, 0, 0, 1);
        repeat (40) begin
            @(posedge i_mclk);
            c_cmd  <= $random(seed) & 1 ? SBCSM_CMD_NOP : SBCSM_CMD_INHIBIT;
            c_bank <= 2'($random(seed));
            c_ap   <= 1'($random(seed));
            c_row  <= 12'($random(seed));
            @(negedge i_mclk);
            chk_bit("accepted", 1'b0, acc);
            chk_st(0, SBCSM_BANK_ACTIVE);
        end
        final_report();
    end
endmodule // sbcsm_tb
